// File: src/battery_charge_sequencer.v
// Charge sequencer: charge state machine, safety timers, indicators, gate drives.
// Assumes comparator results, timeout oscillators and PWM request come from
// the analog front end asynchronously; the clock MCLK runs at 250 MHz.
//
// Notes on behaviour
// - Reset state on power-up, recharge from done, or input dropout or battery overvoltage in any state but fault.
// - Reset state clears timers, commands zero current, releases all three indicators.
// - Leave reset for prequalification only when power, reference and bias are good.
// - Prequalification: one-twentieth current, primary timeout, rapid indicator low only.
// - Prequalification goes to fast charge once battery exceeds undervoltage threshold.
// - Fast charge: full current limit, rapid-phase timeout, rapid indicator low only.
// - Fast charge goes to full charge when battery reaches regulation voltage.
// - Full charge: constant voltage, primary timeout, constant-voltage indicator low only.
// - Full charge goes to top-off on timeout or current at ten percent.
// - Top-off: constant voltage on primary timeout, all indicators released.
// - Top-off timeout enters done; zero current, indicators released, wait for recharge.
// - Bad temperature in fast or full: zero current, rapid timer frozen, primary timer cleared, indicators kept.
// - Prequalification or fast-charge timeout enters fault; fault indicator low only.
// - Primary timer serves prequal, full and top-off; rapid timer serves fast only.
// - No control exists to disable any timeout.
// - Dead time of 50 ns between one gate turning off and the other on.
// - Low-side drive turns off as soon as inductor current reaches zero.
// - Indicators are open-drain: pull low when asserted, otherwise released.
// - Fault is left only by power cycling or by shutdown.
// - Shutdown holds gates low, floats indicators, restarts at reset with cleared timers.
// - Each temperature measurement holds both gates low for 800 us.
`timescale 1ns/1ps
`default_nettype none
`include "charger_map.vh"

module battery_charge_sequencer #(
  parameter [15:0] PREQUAL_TICKS = `PREQUAL_TICKS,
  parameter TEMP_PAUSE_US = `TEMP_PAUSE_US,
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input wire MCLK,
  input wire RST,
  input wire SHUTDOWN_REQUEST_N,
  input wire SUPPLY_MARGIN_LOW,
  input wire BATTERY_OVERVOLTAGE,
  input wire BATTERY_ABOVE_UNDERVOLTAGE,
  input wire BATTERY_AT_REGULATION,
  input wire BATTERY_BELOW_RECHARGE,
  input wire TEMPERATURE_OUT_OF_LIMITS,
  input wire CURRENT_BELOW_TENTH,
  input wire INPUT_POWER_GOOD,
  input wire REFERENCE_GOOD,
  input wire BIAS_GOOD,
  input wire PRIMARY_TIMEOUT_SOURCE,
  input wire RAPID_PHASE_TIMEOUT_SOURCE,
  input wire PWM_HIGH_SIDE_REQUEST,
  input wire INDUCTOR_CURRENT_ZERO,
  input wire TEMPERATURE_MEASURE_START,
  input wire RAPID_PHASE_INDICATOR_N_I,
  input wire CONSTANT_VOLTAGE_INDICATOR_N_I,
  input wire FAULT_INDICATOR_N_I,
  output reg RAPID_PHASE_INDICATOR_N_O,
  output reg RAPID_PHASE_INDICATOR_N_OE,
  output reg CONSTANT_VOLTAGE_INDICATOR_N_O,
  output reg CONSTANT_VOLTAGE_INDICATOR_N_OE,
  output reg FAULT_INDICATOR_N_O,
  output reg FAULT_INDICATOR_N_OE,
  output reg HIGH_SIDE_GATE_DRIVE,
  output reg LOW_SIDE_GATE_DRIVE,
  output reg [1:0] CHARGE_LEVEL,
  output reg [2:0] CHARGE_STATE
);

  // ==========================================================
  // State codes
  localparam [2:0] ST_RESET = 3'h0;
  localparam [2:0] ST_PREQUAL = 3'h1;
  localparam [2:0] ST_FAST = 3'h2;
  localparam [2:0] ST_FULL = 3'h3;
  localparam [2:0] ST_TOPOFF = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;
  localparam [2:0] ST_FAULT = 3'h6;
  localparam [2:0] ST_TEMP_PAUSE = 3'h7;

  // ==========================================================
  // Derived counts; dead time rounds up so it is never short
  localparam integer DEAD_INT = (`DEAD_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
  localparam [3:0] DEAD_CYC = DEAD_INT[3:0];
  localparam integer PAUSE_INT = TEMP_PAUSE_US * (`PS_PER_US / `CLK_PERIOD_PS);
  localparam [17:0] PAUSE_CYC = PAUSE_INT[17:0];
  localparam integer PRE_INT = PREQUAL_TICKS;
  localparam integer FULL_INT = PRE_INT * `FULL_RATIO;
  localparam integer TOPOFF_INT = PRE_INT * `TOPOFF_RATIO;
  localparam integer FAST_INT = PRE_INT * `FAST_RATIO;
  localparam [`TIMER_WIDTH-1:0] PRE_LIMIT = PRE_INT[`TIMER_WIDTH-1:0];
  localparam [`TIMER_WIDTH-1:0] FULL_LIMIT = FULL_INT[`TIMER_WIDTH-1:0];
  localparam [`TIMER_WIDTH-1:0] TOPOFF_LIMIT = TOPOFF_INT[`TIMER_WIDTH-1:0];
  localparam [`TIMER_WIDTH-1:0] FAST_LIMIT = FAST_INT[`TIMER_WIDTH-1:0];

  // ==========================================================
  // Comparator conditioning
  wire [`CMP_COUNT-1:0] cmp_raw;
  wire [`CMP_COUNT-1:0] cmp;

  assign cmp_raw = {BIAS_GOOD, REFERENCE_GOOD, INPUT_POWER_GOOD, CURRENT_BELOW_TENTH,
                    TEMPERATURE_OUT_OF_LIMITS, BATTERY_BELOW_RECHARGE, BATTERY_AT_REGULATION,
                    BATTERY_ABOVE_UNDERVOLTAGE, BATTERY_OVERVOLTAGE, SUPPLY_MARGIN_LOW};

  // No transition sees a comparator before it is filtered
  comparator_conditioner #(
    .WIDTH(`CMP_COUNT),
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
  ) u_cond (
    .clk(MCLK),
    .rst(RST),
    .raw(cmp_raw),
    .clean(cmp)
  );

  // ==========================================================
  // Pin synchronisers for fast or edge-timed inputs
  wire [`PIN_COUNT-1:0] pin_raw;
  reg [`PIN_COUNT-1:0] pin_meta;
  reg [`PIN_COUNT-1:0] pin;
  reg [`PIN_COUNT-1:0] pin_last;

  assign pin_raw = {TEMPERATURE_MEASURE_START, INDUCTOR_CURRENT_ZERO, PWM_HIGH_SIDE_REQUEST,
                    RAPID_PHASE_TIMEOUT_SOURCE, PRIMARY_TIMEOUT_SOURCE, SHUTDOWN_REQUEST_N};

  // Shutdown syncs to idle-released so a reset does not look like shutdown
  always @(posedge MCLK) begin
    if (RST) begin
      pin_meta <= 6'h01;
      pin <= 6'h01;
      pin_last <= 6'h01;
    end else begin
      pin_meta <= pin_raw;
      pin <= pin_meta;
      pin_last <= pin;
    end
  end

  wire shutdown = ~pin[`PIN_SHUTDOWN_N];
  wire primary_tick = pin[`PIN_PRIMARY_SRC] & ~pin_last[`PIN_PRIMARY_SRC];
  wire rapid_tick = pin[`PIN_RAPID_SRC] & ~pin_last[`PIN_RAPID_SRC];
  wire pwm_request = pin[`PIN_PWM_REQUEST];
  wire current_zero = pin[`PIN_CURRENT_ZERO];
  wire measure_start = pin[`PIN_TEMP_MEASURE] & ~pin_last[`PIN_TEMP_MEASURE];

  // ==========================================================
  // Charge state machine
  reg [2:0] state;
  reg [2:0] resume_state;
  reg [2:0] next_state;
  reg [`TIMER_WIDTH-1:0] primary_count;
  reg [`TIMER_WIDTH-1:0] rapid_count;
  reg [`TIMER_WIDTH-1:0] primary_limit;

  wire reset_cause = cmp[`CMP_SUPPLY_MARGIN_LOW] | cmp[`CMP_OVERVOLTAGE];
  wire supplies_good = cmp[`CMP_INPUT_POWER_GOOD] & cmp[`CMP_REFERENCE_GOOD] & cmp[`CMP_BIAS_GOOD];
  wire temp_bad = cmp[`CMP_TEMP_OUT_OF_LIMITS];
  wire primary_expired = (primary_count == primary_limit);
  wire rapid_expired = (rapid_count == FAST_LIMIT);

  // Terminal count of the primary timer follows the phase it times
  always @* begin
    case (state)
      ST_PREQUAL: primary_limit = PRE_LIMIT;
      ST_FULL: primary_limit = FULL_LIMIT;
      ST_TOPOFF: primary_limit = TOPOFF_LIMIT;
      default: primary_limit = PRE_LIMIT;
    endcase
  end

  // Next state; timeouts have no enable, so every timed phase ends
  always @* begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (supplies_good) begin
          next_state = ST_PREQUAL;
        end
      end
      ST_PREQUAL: begin
        if (cmp[`CMP_ABOVE_UNDERVOLTAGE]) begin
          next_state = ST_FAST;
        end else if (primary_expired) begin
          next_state = ST_FAULT;
        end
      end
      ST_FAST: begin
        if (temp_bad) begin
          next_state = ST_TEMP_PAUSE;
        end else if (cmp[`CMP_AT_REGULATION]) begin
          next_state = ST_FULL;
        end else if (rapid_expired) begin
          next_state = ST_FAULT;
        end
      end
      ST_FULL: begin
        if (temp_bad) begin
          next_state = ST_TEMP_PAUSE;
        end else if (primary_expired | cmp[`CMP_CURRENT_BELOW_TENTH]) begin
          next_state = ST_TOPOFF;
        end
      end
      ST_TOPOFF: begin
        if (primary_expired) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (cmp[`CMP_BELOW_RECHARGE]) begin
          next_state = ST_RESET;
        end
      end
      ST_TEMP_PAUSE: begin
        if (!temp_bad) begin
          next_state = resume_state;
        end
      end
      ST_FAULT: next_state = ST_FAULT;
      default: next_state = ST_RESET;
    endcase
    // Dropout and overvoltage win over everything except a latched fault
    if (reset_cause && state != ST_FAULT) begin
      next_state = ST_RESET;
    end
  end

  // State register; shutdown forces reset and, with RST, is the only exit from fault
  always @(posedge MCLK) begin
    if (RST || shutdown) begin
      state <= ST_RESET;
      resume_state <= ST_RESET;
    end else begin
      state <= next_state;
      if (next_state == ST_TEMP_PAUSE && state != ST_TEMP_PAUSE) begin
        resume_state <= state;
      end
    end
  end

  // ==========================================================
  // Safety timers: primary cleared on each phase and pause entry, rapid only in reset; both hold during a pause
  always @(posedge MCLK) begin
    if (RST || shutdown || state == ST_RESET) begin
      primary_count <= {`TIMER_WIDTH{1'b0}};
      rapid_count <= {`TIMER_WIDTH{1'b0}};
    end else if (state == ST_TEMP_PAUSE) begin
      primary_count <= primary_count;
      rapid_count <= rapid_count;
    end else begin
      if (next_state != state) begin
        primary_count <= {`TIMER_WIDTH{1'b0}};
      end else if (primary_tick && !primary_expired &&
                   (state == ST_PREQUAL || state == ST_FULL || state == ST_TOPOFF)) begin
        primary_count <= primary_count + {{(`TIMER_WIDTH-1){1'b0}}, 1'b1};
      end
      if (state == ST_FAST && next_state == ST_FAST && rapid_tick && !rapid_expired) begin
        rapid_count <= rapid_count + {{(`TIMER_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================================
  // Charge level and open-drain indicators; enable high pulls the pin low
  always @(posedge MCLK) begin
    if (RST) begin
      CHARGE_LEVEL <= `LEVEL_ZERO;
      CHARGE_STATE <= ST_RESET;
      RAPID_PHASE_INDICATOR_N_O <= 1'b0;
      CONSTANT_VOLTAGE_INDICATOR_N_O <= 1'b0;
      FAULT_INDICATOR_N_O <= 1'b0;
      RAPID_PHASE_INDICATOR_N_OE <= 1'b0;
      CONSTANT_VOLTAGE_INDICATOR_N_OE <= 1'b0;
      FAULT_INDICATOR_N_OE <= 1'b0;
    end else if (shutdown) begin
      CHARGE_LEVEL <= `LEVEL_ZERO;
      CHARGE_STATE <= ST_RESET;
      RAPID_PHASE_INDICATOR_N_OE <= 1'b0;
      CONSTANT_VOLTAGE_INDICATOR_N_OE <= 1'b0;
      FAULT_INDICATOR_N_OE <= 1'b0;
    end else begin
      CHARGE_STATE <= state;
      case (state)
        ST_PREQUAL: begin
          CHARGE_LEVEL <= `LEVEL_TWENTIETH;
          RAPID_PHASE_INDICATOR_N_OE <= 1'b1;
          CONSTANT_VOLTAGE_INDICATOR_N_OE <= 1'b0;
          FAULT_INDICATOR_N_OE <= 1'b0;
        end
        ST_FAST: begin
          CHARGE_LEVEL <= `LEVEL_CURRENT_LIMIT;
          RAPID_PHASE_INDICATOR_N_OE <= 1'b1;
          CONSTANT_VOLTAGE_INDICATOR_N_OE <= 1'b0;
          FAULT_INDICATOR_N_OE <= 1'b0;
        end
        ST_FULL: begin
          CHARGE_LEVEL <= `LEVEL_CONSTANT_VOLTAGE;
          RAPID_PHASE_INDICATOR_N_OE <= 1'b0;
          CONSTANT_VOLTAGE_INDICATOR_N_OE <= 1'b1;
          FAULT_INDICATOR_N_OE <= 1'b0;
        end
        ST_TOPOFF: begin
          CHARGE_LEVEL <= `LEVEL_CONSTANT_VOLTAGE;
          RAPID_PHASE_INDICATOR_N_OE <= 1'b0;
          CONSTANT_VOLTAGE_INDICATOR_N_OE <= 1'b0;
          FAULT_INDICATOR_N_OE <= 1'b0;
        end
        ST_TEMP_PAUSE: begin
          // Indicators keep whatever the paused phase showed
          CHARGE_LEVEL <= `LEVEL_ZERO;
        end
        ST_FAULT: begin
          CHARGE_LEVEL <= `LEVEL_ZERO;
          RAPID_PHASE_INDICATOR_N_OE <= 1'b0;
          CONSTANT_VOLTAGE_INDICATOR_N_OE <= 1'b0;
          FAULT_INDICATOR_N_OE <= 1'b1;
        end
        default: begin
          // Reset and done: no current, everything released
          CHARGE_LEVEL <= `LEVEL_ZERO;
          RAPID_PHASE_INDICATOR_N_OE <= 1'b0;
          CONSTANT_VOLTAGE_INDICATOR_N_OE <= 1'b0;
          FAULT_INDICATOR_N_OE <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Temperature measurement pause timer
  reg [17:0] pause_count;

  always @(posedge MCLK) begin
    if (RST || shutdown) begin
      pause_count <= 18'h00000;
    end else if (measure_start) begin
      pause_count <= PAUSE_CYC;
    end else if (pause_count != 18'h00000) begin
      pause_count <= pause_count - 18'h00001;
    end
  end

  // ==========================================================
  // Gate drive sequencing
  reg [3:0] dead_count;
  reg low_side_armed;
  wire charging = (state == ST_PREQUAL || state == ST_FAST || state == ST_FULL || state == ST_TOPOFF);
  wire switch_enable = charging & ~shutdown & (pause_count == 18'h00000) & ~measure_start;
  wire dead_done = (dead_count == 4'h0);

  // Every turn-off reloads the dead-time counter; a turn-on waits for it
  // and for the other switch to be off, so the two never overlap.
  // The low side is armed by a high-side pulse and disarmed at zero
  // current, which keeps it from pulling current back out of the cell.
  always @(posedge MCLK) begin
    if (RST || !switch_enable) begin
      HIGH_SIDE_GATE_DRIVE <= 1'b0;
      LOW_SIDE_GATE_DRIVE <= 1'b0;
      low_side_armed <= 1'b0;
      dead_count <= DEAD_CYC;
    end else begin
      if (!dead_done) begin
        dead_count <= dead_count - 4'h1;
      end
      if (HIGH_SIDE_GATE_DRIVE && !pwm_request) begin
        HIGH_SIDE_GATE_DRIVE <= 1'b0;
        low_side_armed <= 1'b1;
        dead_count <= DEAD_CYC;
      end else if (LOW_SIDE_GATE_DRIVE && (current_zero || pwm_request)) begin
        LOW_SIDE_GATE_DRIVE <= 1'b0;
        low_side_armed <= 1'b0;
        dead_count <= DEAD_CYC;
      end else if (!HIGH_SIDE_GATE_DRIVE && !LOW_SIDE_GATE_DRIVE && dead_done) begin
        if (pwm_request) begin
          HIGH_SIDE_GATE_DRIVE <= 1'b1;
        end else if (low_side_armed && !current_zero) begin
          LOW_SIDE_GATE_DRIVE <= 1'b1;
        end else if (current_zero) begin
          low_side_armed <= 1'b0;
        end
      end
    end
  end

endmodule // battery_charge_sequencer

`default_nettype wire

// File: src/charger_map.vh
// Constants shared by the charge sequencer and its input conditioner.
// Assumes one 250 MHz clock; times are kept in their own units here.
`ifndef CHARGER_MAP_VH
`define CHARGER_MAP_VH

// ==========================================================
// Clock and timing
`define CLK_PERIOD_PS 4000
`define DEAD_TIME_PS 50000
`define TEMP_PAUSE_US 800
`define PS_PER_US 1000000

// ==========================================================
// Phase timeouts, in ticks of the timeout sources
`define PREQUAL_TICKS 16'h0040
`define FULL_RATIO 12
`define TOPOFF_RATIO 6
`define FAST_RATIO 12
`define TIMER_WIDTH 20

// ==========================================================
// Comparator input conditioning
`define DEBOUNCE_CYCLES 8
`define CMP_COUNT 10
`define CMP_SUPPLY_MARGIN_LOW 0
`define CMP_OVERVOLTAGE 1
`define CMP_ABOVE_UNDERVOLTAGE 2
`define CMP_AT_REGULATION 3
`define CMP_BELOW_RECHARGE 4
`define CMP_TEMP_OUT_OF_LIMITS 5
`define CMP_CURRENT_BELOW_TENTH 6
`define CMP_INPUT_POWER_GOOD 7
`define CMP_REFERENCE_GOOD 8
`define CMP_BIAS_GOOD 9

// ==========================================================
// Charge level command codes
`define LEVEL_ZERO 2'h0
`define LEVEL_TWENTIETH 2'h1
`define LEVEL_CURRENT_LIMIT 2'h2
`define LEVEL_CONSTANT_VOLTAGE 2'h3

// ==========================================================
// Pin synchroniser bit positions
`define PIN_SHUTDOWN_N 0
`define PIN_PRIMARY_SRC 1
`define PIN_RAPID_SRC 2
`define PIN_PWM_REQUEST 3
`define PIN_CURRENT_ZERO 4
`define PIN_TEMP_MEASURE 5
`define PIN_COUNT 6

`endif

// File: src/comparator_conditioner.v
// Synchroniser and debounce filter for the analog comparator results.
// Assumes raw inputs are asynchronous levels; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "charger_map.vh"

module comparator_conditioner #(
  parameter WIDTH = `CMP_COUNT,
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] raw,
  output reg [WIDTH-1:0] clean
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  // ==========================================================
  // Two-flop synchroniser; meta is read by stable alone
  always @(posedge clk) begin
    if (rst) begin
      meta <= {WIDTH{1'b0}};
      stable <= {WIDTH{1'b0}};
    end else begin
      meta <= raw;
      stable <= meta;
    end
  end

  // ==========================================================
  // Per-bit filter: a new level must hold DEBOUNCE_CYCLES before it counts
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_filter
      reg [7:0] hold;
      always @(posedge clk) begin
        if (rst) begin
          hold <= 8'h00;
          clean[i] <= 1'b0;
        end else if (stable[i] == clean[i]) begin
          hold <= 8'h00;
        end else if (hold == DEBOUNCE_CYCLES[7:0] - 8'h01) begin
          hold <= 8'h00;
          clean[i] <= stable[i];
        end else begin
          hold <= hold + 8'h01;
        end
      end
    end
  endgenerate

endmodule // comparator_conditioner

`default_nettype wire

// File: tb/charger_checker_sva.sv
// Port checker for the charge sequencer, bound into every instance.
// Assumes MCLK is the only clock and RST is synchronous, active high.
`timescale 1ns/1ps
`default_nettype none
module charger_checker (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SHUTDOWN_REQUEST_N,
  input wire logic INDUCTOR_CURRENT_ZERO,
  input wire logic TEMPERATURE_MEASURE_START,
  input wire logic RAPID_PHASE_INDICATOR_N_OE,
  input wire logic CONSTANT_VOLTAGE_INDICATOR_N_OE,
  input wire logic FAULT_INDICATOR_N_OE,
  input wire logic HIGH_SIDE_GATE_DRIVE,
  input wire logic LOW_SIDE_GATE_DRIVE,
  input wire logic [1:0] CHARGE_LEVEL,
  input wire logic [2:0] CHARGE_STATE
);
  // ====
  // Grouped outputs
  logic [2:0] oe;
  logic [1:0] gates;
  assign oe = {RAPID_PHASE_INDICATOR_N_OE, CONSTANT_VOLTAGE_INDICATOR_N_OE, FAULT_INDICATOR_N_OE};
  assign gates = {HIGH_SIDE_GATE_DRIVE, LOW_SIDE_GATE_DRIVE};
  // ====
  // Properties; reset masks every check
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  reset_outputs_a: assert property (CHARGE_STATE == 3'h0 |-> oe == 3'h0 && CHARGE_LEVEL == 2'h0 && gates == 2'h0)
    else $error("reset state outputs wrong");
  prequal_outputs_a: assert property (CHARGE_STATE == 3'h1 |-> oe == 3'h4 && CHARGE_LEVEL == 2'h1)
    else $error("prequalification outputs wrong");
  fast_outputs_a: assert property (CHARGE_STATE == 3'h2 |-> oe == 3'h4 && CHARGE_LEVEL == 2'h2)
    else $error("fast charge outputs wrong");
  full_outputs_a: assert property (CHARGE_STATE == 3'h3 |-> oe == 3'h2 && CHARGE_LEVEL == 2'h3)
    else $error("full charge outputs wrong");
  finish_outputs_a: assert property (CHARGE_STATE inside {3'h4, 3'h5} |-> oe == 3'h0 &&
    CHARGE_LEVEL == (CHARGE_STATE == 3'h4 ? 2'h3 : 2'h0))
    else $error("top-off or done outputs wrong");
  fault_outputs_a: assert property (CHARGE_STATE == 3'h6 |-> oe == 3'h1 && CHARGE_LEVEL == 2'h0 && gates == 2'h0)
    else $error("fault outputs wrong");
  pause_outputs_a: assert property (CHARGE_STATE == 3'h7 |-> CHARGE_LEVEL == 2'h0 && gates == 2'h0 && $stable(oe))
    else $error("temperature pause outputs wrong");
  fault_sticky_a: assert property (SHUTDOWN_REQUEST_N [*4] ##0 CHARGE_STATE == 3'h6 |=> CHARGE_STATE == 3'h6)
    else $error("fault left without shutdown");
  shutdown_quiet_a: assert property (!SHUTDOWN_REQUEST_N [*4] |=> CHARGE_STATE == 3'h0 && oe == 3'h0 && gates == 2'h0)
    else $error("shutdown not honoured");
  hs_ls_dead_a: assert property ($fell(HIGH_SIDE_GATE_DRIVE) |-> !LOW_SIDE_GATE_DRIVE [*8])
    else $error("low side on inside dead time");
  ls_hs_dead_a: assert property ($fell(LOW_SIDE_GATE_DRIVE) |-> !HIGH_SIDE_GATE_DRIVE [*8])
    else $error("high side on inside dead time");
  zero_current_off_a: assert property (INDUCTOR_CURRENT_ZERO [*4] |-> !LOW_SIDE_GATE_DRIVE)
    else $error("low side on at zero current");
  measure_pause_a: assert property ($rose(TEMPERATURE_MEASURE_START) |-> ##5 (gates == 2'h0) [*8])
    else $error("gates switch during measurement");
endmodule // charger_checker

bind battery_charge_sequencer charger_checker u_checker (.MCLK, .RST, .SHUTDOWN_REQUEST_N, .INDUCTOR_CURRENT_ZERO,
  .TEMPERATURE_MEASURE_START, .RAPID_PHASE_INDICATOR_N_OE, .CONSTANT_VOLTAGE_INDICATOR_N_OE,
  .FAULT_INDICATOR_N_OE, .HIGH_SIDE_GATE_DRIVE, .LOW_SIDE_GATE_DRIVE, .CHARGE_LEVEL, .CHARGE_STATE);
`default_nettype wire

// File: tb/power_stage_model.sv
// Far side: inductor current, indicator pull-ups, timeout oscillator.
// Assumes the bench gates the oscillator with osc_on while phases are timed.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model #(
  parameter HALF = 4
) (
  input wire logic clk,
  input wire logic osc_on,
  input wire logic high_side,
  input wire logic low_side,
  input wire logic [2:0] ind_oe,
  input wire logic [2:0] ind_o,
  output logic [2:0] ind_pin,
  output logic current_zero,
  output logic osc
);
  logic [5:0] current = 6'h00;
  logic [3:0] phase = 4'h0;
  initial osc = 1'b0;
  // ====
  // Pulled-up open-drain lines: released pins read high
  assign ind_pin = (ind_oe & ind_o) | ~ind_oe;
  assign current_zero = current == 6'h00;
  // Current ramps with the switch on; the rectifier drains it faster than the diode
  always @(posedge clk) begin
    if (high_side)
      current <= current > 6'h3b ? 6'h3f : current + 6'h04;
    else if (current != 6'h00)
      current <= (low_side && current > 6'h01) ? current - 6'h02 : current - 6'h01;
  end
  // Oscillator halts while disabled so phase counts stay predictable
  always @(posedge clk) begin
    if (osc_on) begin
      phase <= phase == HALF - 1 ? 4'h0 : phase + 4'h1;
      if (phase == HALF - 1)
        osc <= ~osc;
    end
  end
endmodule // power_stage_model
`default_nettype wire

// File: tb/tb.sv
// Bench for the charge sequencer: drives comparators, pins and PWM request.
// Assumes checker and far-side model are compiled first; MCLK at 250 MHz.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic shutdown_request_n_n = 1'b1, sml = 1'b0, ov = 1'b0, uv = 1'b0, at_reg = 1'b0, rech = 1'b0, temp_bad = 1'b0;
  logic tenth = 1'b0, pwr = 1'b0, refg = 1'b0, bias = 1'b0, pwm = 1'b0, tms = 1'b0, osc_on = 1'b0;
  logic osc, izero, hs, ls;
  logic [2:0] oe, od, pins, st;
  logic [1:0] lvl;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // ====
  // Clock, design and far side
  initial forever #2 MCLK = ~MCLK;
  battery_charge_sequencer #(.PREQUAL_TICKS(16'h0004), .TEMP_PAUSE_US(1), .DEBOUNCE_CYCLES(8)) DUT (
    .MCLK(MCLK), .RST(RST), .SHUTDOWN_REQUEST_N(shutdown_request_n_n), .SUPPLY_MARGIN_LOW(sml),
    .BATTERY_OVERVOLTAGE(ov), .BATTERY_ABOVE_UNDERVOLTAGE(uv), .BATTERY_AT_REGULATION(at_reg),
    .BATTERY_BELOW_RECHARGE(rech), .TEMPERATURE_OUT_OF_LIMITS(temp_bad), .CURRENT_BELOW_TENTH(tenth),
    .INPUT_POWER_GOOD(pwr), .REFERENCE_GOOD(refg), .BIAS_GOOD(bias), .PRIMARY_TIMEOUT_SOURCE(osc),
    .RAPID_PHASE_TIMEOUT_SOURCE(osc), .PWM_HIGH_SIDE_REQUEST(pwm), .INDUCTOR_CURRENT_ZERO(izero),
    .TEMPERATURE_MEASURE_START(tms), .RAPID_PHASE_INDICATOR_N_I(pins[2]),
    .CONSTANT_VOLTAGE_INDICATOR_N_I(pins[1]), .FAULT_INDICATOR_N_I(pins[0]),
    .RAPID_PHASE_INDICATOR_N_O(od[2]), .RAPID_PHASE_INDICATOR_N_OE(oe[2]),
    .CONSTANT_VOLTAGE_INDICATOR_N_O(od[1]), .CONSTANT_VOLTAGE_INDICATOR_N_OE(oe[1]),
    .FAULT_INDICATOR_N_O(od[0]), .FAULT_INDICATOR_N_OE(oe[0]), .HIGH_SIDE_GATE_DRIVE(hs),
    .LOW_SIDE_GATE_DRIVE(ls), .CHARGE_LEVEL(lvl), .CHARGE_STATE(st));
  power_stage_model u_stage (.clk(MCLK), .osc_on(osc_on), .high_side(hs), .low_side(ls), .ind_oe(oe),
    .ind_o(od), .ind_pin(pins), .current_zero(izero), .osc(osc));
  // ====
  // Access and compare tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  // Bounded wait for a state, then its indicator pins and current level
  task automatic expect_state(input logic [2:0] s, input logic [2:0] p, input logic [1:0] l, input int n);
    for (int i = 0; i < n && st !== s; i++) @(negedge MCLK);
    chk("state", {5'h0, s}, {5'h0, st});
    chk("pins", {5'h0, p}, {5'h0, pins});
    chk("level", {6'h0, l}, {6'h0, lvl});
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard: the sequence needs about 2400 cycles
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ====
  // Test sequence; inputs change on the falling edge
  initial begin
    idle(4);
    RST = 1'b0;
    expect_state(3'h0, 3'h7, 2'h0, 1);
    pwr = 1'b1;
    refg = 1'b1;
    idle(40);
    expect_state(3'h0, 3'h7, 2'h0, 1);
    bias = 1'b1;
    expect_state(3'h1, 3'h3, 2'h1, 30);
    osc_on = 1'b1;
    idle(20);
    expect_state(3'h1, 3'h3, 2'h1, 1);
    expect_state(3'h6, 3'h6, 2'h0, 60);
    sml = 1'b1;
    uv = 1'b1;
    idle(30);
    expect_state(3'h6, 3'h6, 2'h0, 1);
    sml = 1'b0;
    osc_on = 1'b0;
    shutdown_request_n_n = 1'b0;
    idle(6);
    expect_state(3'h0, 3'h7, 2'h0, 1);
    shutdown_request_n_n = 1'b1;
    expect_state(3'h2, 3'h3, 2'h2, 40);
    pwm = 1'b1;
    idle(20);
    chk("high side", 8'h1, {7'h0, hs});
    pwm = 1'b0;
    idle(24);
    chk("low side", 8'h1, {7'h0, ls});
    idle(70);
    chk("low side", 8'h0, {7'h0, ls});
    pwm = 1'b1;
    idle(10);
    tms = 1'b1;
    idle(8);
    chk("high side", 8'h0, {7'h0, hs});
    tms = 1'b0;
    idle(290);
    chk("high side", 8'h1, {7'h0, hs});
    pwm = 1'b0;
    osc_on = 1'b1;
    idle(100);
    temp_bad = 1'b1;
    expect_state(3'h7, 3'h3, 2'h0, 20);
    idle(400);
    expect_state(3'h7, 3'h3, 2'h0, 1);
    temp_bad = 1'b0;
    expect_state(3'h2, 3'h3, 2'h2, 20);
    idle(200);
    expect_state(3'h2, 3'h3, 2'h2, 1);
    at_reg = 1'b1;
    expect_state(3'h3, 3'h5, 2'h3, 20);
    temp_bad = 1'b1;
    expect_state(3'h7, 3'h5, 2'h0, 20);
    temp_bad = 1'b0;
    expect_state(3'h3, 3'h5, 2'h3, 20);
    idle(250);
    expect_state(3'h3, 3'h5, 2'h3, 1);
    expect_state(3'h4, 3'h7, 2'h3, 250);
    idle(150);
    expect_state(3'h4, 3'h7, 2'h3, 1);
    expect_state(3'h5, 3'h7, 2'h0, 80);
    idle(30);
    expect_state(3'h5, 3'h7, 2'h0, 1);
    rech = 1'b1;
    expect_state(3'h0, 3'h7, 2'h0, 20);
    rech = 1'b0;
    expect_state(3'h3, 3'h5, 2'h3, 40);
    tenth = 1'b1;
    expect_state(3'h4, 3'h7, 2'h3, 20);
    tenth = 1'b0;
    at_reg = 1'b0;
    ov = 1'b1;
    expect_state(3'h0, 3'h7, 2'h0, 20);
    ov = 1'b0;
    expect_state(3'h2, 3'h3, 2'h2, 40);
    expect_state(3'h6, 3'h6, 2'h0, 450);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
